//--- hw/trace_trigger_unit_map.vh
// Register indexes, field positions, reset values and sizes of the trace trigger unit
`ifndef TRACE_TRIGGER_UNIT_MAP_VH
`define TRACE_TRIGGER_UNIT_MAP_VH
// Register indexes; byte address on the bus is four times the index
`define IDX_CA_HI   14'h3010
`define IDX_CA_LO   14'h3011
`define IDX_CB_HI   14'h3012
`define IDX_CB_LO   14'h3013
`define IDX_CC_HI   14'h3014
`define IDX_CC_LO   14'h3015
`define IDX_FIFO_HI 14'h3016
`define IDX_FIFO_LO 14'h3017
`define IDX_CA_EXT  14'h3018
`define IDX_CB_EXT  14'h3019
`define IDX_CC_EXT  14'h301A
`define IDX_FIFO_X  14'h301B
`define IDX_CTRL    14'h301C
`define IDX_TRIG    14'h301D
`define IDX_STATE   14'h301E
`define IDX_COUNT   14'h301F
// Reset values
`define RST_CA_HI   8'hFF
`define RST_CA_LO   8'hFE
`define RST_ZERO    8'h00
`define RST_CTRL    8'hC0
`define RST_TRIG    8'h40
// Control fields
`define CTRL_EN     7
`define CTRL_ARM    6
`define CTRL_TAG    5
`define CTRL_BRK    4
`define CTRL_LOOP   3
// Trigger setup fields
`define TRIG_BEGIN  6
`define TRIG_MODE_H 3
// Extension fields: access-type check enable, expected write level and comparator C breakpoint enable
`define EXT_RWE     7
`define EXT_RW      6
`define EXT_CBRK    5
// Trigger modes
`define MODE_A      4'h0
`define MODE_A_OR_B 4'h1
`define MODE_A_THEN 4'h2
`define MODE_A_DAT  4'h3
`define MODE_A_NDAT 4'h4
`define MODE_EVT_B  4'h5
`define MODE_A_EVT  4'h6
`define MODE_INSIDE 4'h7
`define MODE_OUTSID 4'h8
// Trace state fields
`define ST_AF       7
`define ST_BF       6
`define ST_CF       5
`define ST_TRIGD    4
`define ST_EMPTY    0
// Trace buffer
`define FIFO_DEPTH  8
`define FIFO_AW     3
`define FIFO_CW     4
`endif

//--- hw/trace_trigger_unit.v
// Trace and trigger unit: comparators, trigger modes, trace buffer and register slave
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`include "trace_trigger_unit_map.vh"

// Design notes
// One byte register per bus word; byte address is four times the index.
// The bus answers after one wait state; ack is a one-cycle pulse.
// Reading the low buffer byte pops the head entry.
// Software must read high byte and extra info before the low byte.
// Event modes log data and stop when the buffer is full.
// End-mode flow logging also stops when the eighth entry fills the buffer, so the first eight entries survive.
// Begin-mode logs flow addresses after the trigger until full.
// End-trace system reset of an enabled unit keeps contents and only clears the arm bit.
// Any other system reset reloads the power-on defaults.
// Loop capture checks C only: simple repeats are skipped, long loops not.
// Comparator C gives no standalone breakpoint during loop capture.
// Breakpoint requests are pulses; the core keeps a tag itself.
// Secured parts and debug commands silence comparators at their input.
// Comparators are exact matches; no masking of address bits.
// All observation inputs share this clock and need no synchroniser.
// Buffer entries themselves carry no reset, only pointers and count.

module trace_trigger_unit (
    // Clock and resets
    input  wire        ref_clk_i,
    input  wire        reset_i,
    input  wire        sys_reset_i,
    // Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [15:0] wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // CPU bus observation
    input  wire        cpu_valid_i,
    input  wire        cpu_write_i,
    input  wire [15:0] cpu_addr_i,
    input  wire [7:0]  cpu_data_i,
    // Change-of-flow report from the core
    input  wire        change_of_flow_i,
    input  wire [15:0] change_of_flow_addr_i,
    // System state
    input  wire        secure_i,
    input  wire        background_debug_state_i,
    // Breakpoint requests and trace status
    output reg         tag_bkpt_o,
    output reg         force_bkpt_o,
    output reg         trace_active_o
);

    // Software visible registers, plus the internal A-seen flag
    reg [7:0] ca_hi_ff;
    reg [7:0] ca_lo_ff;
    reg [7:0] cb_hi_ff;
    reg [7:0] cb_lo_ff;
    reg [7:0] cc_hi_ff;
    reg [7:0] cc_lo_ff;
    reg [7:0] ca_ext_ff;
    reg [7:0] cb_ext_ff;
    reg [7:0] cc_ext_ff;
    reg [7:0] ctrl_ff;
    reg [7:0] trig_ff;
    reg       flag_a_ff;
    reg       flag_b_ff;
    reg       flag_c_ff;
    reg       trigd_ff;
    reg       a_seen_ff;

    // Trace buffer storage, bit 16 marks a data entry
    reg [16:0]            fifo_mem [0:`FIFO_DEPTH-1];
    reg [`FIFO_AW-1:0]    wr_ptr_ff;
    reg [`FIFO_AW-1:0]    rd_ptr_ff;
    reg [`FIFO_CW-1:0]    cnt_ff;

    // Bus decode
    wire        bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        bus_wr   = bus_req & wb_we_i & wb_sel_i[0];
    wire [13:0] bus_idx  = wb_adr_i[15:2];
    wire [7:0]  wdat     = wb_dat_i[7:0];

    // Register fields
    wire [15:0] cmp_a    = {ca_hi_ff, ca_lo_ff};
    wire [15:0] cmp_b    = {cb_hi_ff, cb_lo_ff};
    wire [15:0] cmp_c    = {cc_hi_ff, cc_lo_ff};
    wire [3:0]  mode     = trig_ff[`TRIG_MODE_H:0];
    wire        begin_md = trig_ff[`TRIG_BEGIN];
    wire        loop_md  = ctrl_ff[`CTRL_LOOP];

    // Secured part keeps the unit off regardless of software
    wire        unit_on  = ctrl_ff[`CTRL_EN] & ~secure_i;
    wire        tracing  = unit_on & ctrl_ff[`CTRL_ARM];

    // Comparators see only user cycles, never debug command cycles
    wire        watch    = cpu_valid_i & unit_on & ~background_debug_state_i;

    // Access-type qualifier and address match per comparator
    // Index 0 is A, 1 is B, 2 is C; one loop keeps the paths alike
    wire [47:0] cmp_all = {cmp_c, cmp_b, cmp_a};
    wire [23:0] ext_all = {cc_ext_ff, cb_ext_ff, ca_ext_ff};
    wire [2:0]  rw_ok;
    wire [2:0]  adr_eq;
    genvar      gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_cmp
            // Access check applies only while its enable bit is set
            assign rw_ok[gi]  = ~ext_all[gi*8+`EXT_RWE] | (ext_all[gi*8+`EXT_RW] == cpu_write_i);
            // Each register bit names the level its address bit must show
            assign adr_eq[gi] = (cpu_addr_i == cmp_all[gi*16 +: 16]);
        end
    endgenerate
    wire        rw_a = rw_ok[0];
    wire        rw_b = rw_ok[1];
    wire        rw_c = rw_ok[2];

    // Full configuration: B compares data and its high byte is unused
    wire        full_cfg = (mode == `MODE_A_DAT) | (mode == `MODE_A_NDAT);
    wire        data_eq  = (cpu_data_i == cb_lo_ff);

    // Bitwise match: each register bit names the required address level
    wire        hit_a = watch & rw_a & adr_eq[0];
    wire        hit_b = watch & rw_b & ~full_cfg & adr_eq[1];
    wire        hit_c = watch & rw_c & adr_eq[2];
    wire        in_rng = watch & (cpu_addr_i >= cmp_a) & (cpu_addr_i <= cmp_b);
    wire        out_rng = watch & ((cpu_addr_i < cmp_a) | (cpu_addr_i > cmp_b));

    // Event-only modes log data rather than flow addresses
    wire        evt_md = (mode == `MODE_EVT_B) | (mode == `MODE_A_EVT);

    // Trigger selection
    // Sequence modes rely on the sticky A-seen flag, cleared on rearm
    // Unused mode codes never trigger rather than alias a real mode
    reg trig_now;
    always @* begin
        case (mode)
            `MODE_A:      trig_now = hit_a;
            `MODE_A_OR_B: trig_now = hit_a | hit_b;
            `MODE_A_THEN: trig_now = a_seen_ff & hit_b;
            `MODE_A_DAT:  trig_now = hit_a & data_eq;
            `MODE_A_NDAT: trig_now = hit_a & ~data_eq;
            `MODE_EVT_B:  trig_now = hit_b;
            `MODE_A_EVT:  trig_now = a_seen_ff & hit_b;
            `MODE_INSIDE: trig_now = in_rng;
            `MODE_OUTSID: trig_now = out_rng;
            default:      trig_now = 1'b0;
        endcase
    end

    // Loop capture skips a flow address equal to the last one stored
    wire        loop_rpt = loop_md & (change_of_flow_addr_i == cmp_c);

    // Flow records: begin-mode waits for the trigger, end-mode logs until it
    wire        cof_push = tracing & ~evt_md & change_of_flow_i & ~loop_rpt &
                           (~begin_md | trigd_ff);
    wire        evt_push = tracing & evt_md & trig_now;
    wire        push     = cof_push | evt_push;
    wire [16:0] push_val = evt_push ? {1'b1, 8'h00, cpu_data_i} :
                                      {1'b0, change_of_flow_addr_i};
    wire        full     = (cnt_ff == `FIFO_DEPTH);
    wire        empty    = (cnt_ff == {`FIFO_CW{1'b0}});

    // End-mode rearmed on a full buffer overwrites the oldest entry; other modes stop when full
    // Dropping the oldest keeps history nearest the trigger in end-mode
    wire        wrap     = full & ~begin_md & ~evt_md;
    wire        do_push  = push & (~full | wrap);
    wire        pop      = bus_req & ~wb_we_i & (bus_idx == `IDX_FIFO_LO) & ~empty;
    wire        drop     = do_push & wrap;
    wire        fill_end = do_push & ~wrap & (cnt_ff == `FIFO_DEPTH - 1);

    // Trace ends on trigger in end-mode, or once the buffer fills
    wire        done = tracing & ((~begin_md & ~evt_md & trig_now) | fill_end);

    // Breakpoint request: from a trigger or from comparator C alone
    wire        c_brk = hit_c & cc_ext_ff[`EXT_CBRK] & ~loop_md;
    wire        brk   = tracing & ctrl_ff[`CTRL_BRK] & trig_now;
    wire        brk_any = brk | (unit_on & c_brk);

    // End-trace reset of an enabled unit keeps contents; any other reset reloads defaults
    // Undefined contents after a begin-trace reset are modelled as defaults
    wire        keep  = sys_reset_i & ctrl_ff[`CTRL_EN] & ~begin_md;
    wire        init  = reset_i | (sys_reset_i & ~keep);

    // Head entry and pointer arithmetic
    // Pointers wrap naturally at the power-of-two depth
    wire [16:0]         head   = empty ? 17'h00000 : fifo_mem[rd_ptr_ff];
    wire [`FIFO_AW-1:0] wr_nxt = wr_ptr_ff + {{(`FIFO_AW-1){1'b0}}, 1'b1};
    wire [`FIFO_AW-1:0] rd_nxt = rd_ptr_ff + {{(`FIFO_AW-1){1'b0}}, 1'b1};

    // Software registers; hardware loop update of C wins over a write
    // Read-only words fall to the default branch and change nothing
    // Trace end and end-trace reset both clear the arm bit last
    always @(posedge ref_clk_i) begin
        if (init) begin
            ca_hi_ff  <= `RST_CA_HI;
            ca_lo_ff  <= `RST_CA_LO;
            cb_hi_ff  <= `RST_ZERO;
            cb_lo_ff  <= `RST_ZERO;
            cc_hi_ff  <= `RST_ZERO;
            cc_lo_ff  <= `RST_ZERO;
            ca_ext_ff <= `RST_ZERO;
            cb_ext_ff <= `RST_ZERO;
            cc_ext_ff <= `RST_ZERO;
            ctrl_ff   <= `RST_CTRL;
            trig_ff   <= `RST_TRIG;
        end else begin
            if (bus_wr) begin
                case (bus_idx)
                    `IDX_CA_HI:  ca_hi_ff  <= wdat;
                    `IDX_CA_LO:  ca_lo_ff  <= wdat;
                    `IDX_CB_HI:  cb_hi_ff  <= wdat;
                    `IDX_CB_LO:  cb_lo_ff  <= wdat;
                    `IDX_CC_HI:  cc_hi_ff  <= wdat;
                    `IDX_CC_LO:  cc_lo_ff  <= wdat;
                    `IDX_CA_EXT: ca_ext_ff <= wdat;
                    `IDX_CB_EXT: cb_ext_ff <= wdat;
                    `IDX_CC_EXT: cc_ext_ff <= wdat;
                    `IDX_CTRL:   ctrl_ff   <= wdat;
                    `IDX_TRIG:   trig_ff   <= wdat;
                    default:     ctrl_ff   <= ctrl_ff;
                endcase
            end
            if (cof_push & loop_md) begin
                cc_hi_ff <= change_of_flow_addr_i[15:8];
                cc_lo_ff <= change_of_flow_addr_i[7:0];
            end
            if (done) begin
                ctrl_ff[`CTRL_ARM] <= 1'b0;
            end
            if (keep) begin
                ctrl_ff[`CTRL_ARM] <= 1'b0;
            end
        end
    end

    // Sticky match flags; rearming clears them, a new match wins
    // Set beats clear so a hit in the rearm cycle is never lost
    wire arm_wr = bus_wr & (bus_idx == `IDX_CTRL) & wdat[`CTRL_ARM];
    always @(posedge ref_clk_i) begin
        if (init) begin
            flag_a_ff <= 1'b0;
            flag_b_ff <= 1'b0;
            flag_c_ff <= 1'b0;
            trigd_ff  <= 1'b0;
            a_seen_ff <= 1'b0;
        end else begin
            flag_a_ff <= hit_a | (flag_a_ff & ~arm_wr);
            flag_b_ff <= hit_b | (flag_b_ff & ~arm_wr);
            flag_c_ff <= hit_c | (flag_c_ff & ~arm_wr);
            trigd_ff  <= (tracing & trig_now) | (trigd_ff & ~arm_wr);
            a_seen_ff <= (tracing & hit_a) | (a_seen_ff & ~arm_wr);
        end
    end

    // Trace buffer pointers and fill count
    // A non-wrapping push and a pop together leave the count unchanged
    // A wrapping push with a pop still loses only one entry net
    always @(posedge ref_clk_i) begin
        if (init) begin
            wr_ptr_ff <= {`FIFO_AW{1'b0}};
            rd_ptr_ff <= {`FIFO_AW{1'b0}};
            cnt_ff    <= {`FIFO_CW{1'b0}};
        end else begin
            if (do_push) begin
                wr_ptr_ff <= wr_nxt;
            end
            if (pop | drop) begin
                rd_ptr_ff <= rd_nxt;
            end
            if (do_push & ~drop & ~pop) begin
                cnt_ff <= cnt_ff + {{(`FIFO_CW-1){1'b0}}, 1'b1};
            end else if (pop & ~do_push) begin
                cnt_ff <= cnt_ff - {{(`FIFO_CW-1){1'b0}}, 1'b1};
            end else if (pop & drop) begin
                cnt_ff <= cnt_ff - {{(`FIFO_CW-1){1'b0}}, 1'b1};
            end
        end
    end

    // Entry storage needs no reset; an empty buffer reads zero
    always @(posedge ref_clk_i) begin
        if (do_push) begin
            fifo_mem[wr_ptr_ff] <= push_val;
        end
    end

    // Read mux; unmapped words read zero
    // Decoded on the full index so aliases never answer
    reg [7:0] rd_mux;
    always @* begin
        case (bus_idx)
            `IDX_CA_HI:   rd_mux = ca_hi_ff;
            `IDX_CA_LO:   rd_mux = ca_lo_ff;
            `IDX_CB_HI:   rd_mux = cb_hi_ff;
            `IDX_CB_LO:   rd_mux = cb_lo_ff;
            `IDX_CC_HI:   rd_mux = cc_hi_ff;
            `IDX_CC_LO:   rd_mux = cc_lo_ff;
            `IDX_FIFO_HI: rd_mux = head[15:8];
            `IDX_FIFO_LO: rd_mux = head[7:0];
            `IDX_CA_EXT:  rd_mux = ca_ext_ff;
            `IDX_CB_EXT:  rd_mux = cb_ext_ff;
            `IDX_CC_EXT:  rd_mux = cc_ext_ff;
            `IDX_FIFO_X:  rd_mux = {head[16], 6'h00, ~empty};
            `IDX_CTRL:    rd_mux = ctrl_ff;
            `IDX_TRIG:    rd_mux = trig_ff;
            `IDX_STATE:   rd_mux = {flag_a_ff, flag_b_ff, flag_c_ff, trigd_ff, 3'h0, empty};
            `IDX_COUNT:   rd_mux = {4'h0, cnt_ff};
            default:      rd_mux = 8'h00;
        endcase
    end

    // Single-wait-state answer; ack drops the cycle after it is given
    // Data is zero outside ack so a stale read never leaks
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? {24'h000000, rd_mux} : 32'h00000000;
        end
    end

    // Breakpoint pulses; the core holds a tag until the opcode executes
    // Tag and force are exclusive; the control bit picks one
    always @(posedge ref_clk_i) begin
        if (init) begin
            tag_bkpt_o     <= 1'b0;
            force_bkpt_o   <= 1'b0;
            trace_active_o <= 1'b0;
        end else begin
            tag_bkpt_o     <= brk_any & ctrl_ff[`CTRL_TAG];
            force_bkpt_o   <= brk_any & ~ctrl_ff[`CTRL_TAG];
            trace_active_o <= tracing & ~done;
        end
    end

endmodule

//--- verification/trace_trigger_unit_checker.sv
// Checker of the trace trigger unit's bus and breakpoint outputs
`timescale 1ns/10ps
module trace_trigger_unit_checker (
    // Clock and reset
    input wire        ref_clk_i,
    input wire        reset_i,
    // Register bus
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    // Observation and requests
    input wire        cpu_valid_i,
    input wire        secure_i,
    input wire        background_debug_state_i,
    input wire        tag_bkpt_o,
    input wire        force_bkpt_o,
    input wire        trace_active_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // New request not yet answered, and any breakpoint request
    wire req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire bkpt = tag_bkpt_o || force_bkpt_o;

    a_ack_after_req: assert property (req |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_has_cause: assert property (wb_ack_o |-> $past(req))
        else $error("ack without a taken request");
    a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    a_upper_bytes_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bytes not zero");
    a_secure_no_bkpt: assert property ($past(secure_i) |-> !bkpt)
        else $error("breakpoint while secured");
    a_debug_no_match: assert property ($past(background_debug_state_i) |-> !bkpt)
        else $error("breakpoint during debug command");
    a_bkpt_has_cycle: assert property (bkpt |-> $past(cpu_valid_i))
        else $error("breakpoint without a bus cycle");
    a_one_bkpt_kind: assert property (!(tag_bkpt_o && force_bkpt_o))
        else $error("tagged and forced breakpoint together");
    a_secure_stops_trace: assert property (secure_i [*2] |-> !trace_active_o)
        else $error("trace running while secured");

    // Main scenarios reached
    c_force: cover property (force_bkpt_o);
    c_tag: cover property (tag_bkpt_o);
    c_read_data: cover property (wb_ack_o && wb_dat_o != 32'h0);
    c_trace_stop: cover property (trace_active_o ##1 !trace_active_o);
endmodule

//--- verification/cpu_bus_model.sv
// Model of the CPU core buses watched by the trace trigger unit
`timescale 1ns/10ps
module cpu_bus_model (
    // Clock
    input  wire         ref_clk_i,
    // Bus cycle
    output logic        cpu_valid_o,
    output logic        cpu_write_o,
    output logic [15:0] cpu_addr_o,
    output logic [7:0]  cpu_data_o,
    // Change-of-flow report
    output logic        change_of_flow_o,
    output logic [15:0] change_of_flow_addr_o
);
    // Idle at time zero
    initial begin
        {cpu_valid_o, cpu_write_o, cpu_addr_o, cpu_data_o} = 26'h0;
        {change_of_flow_o, change_of_flow_addr_o} = 17'h0;
    end
    // One bus cycle; released lines show the inverse so stale values never match
    task bus(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        {cpu_valid_o, cpu_write_o, cpu_addr_o, cpu_data_o} <= {2'b11, a, d};
        @(posedge ref_clk_i);
        {cpu_valid_o, cpu_write_o, cpu_addr_o, cpu_data_o} <= {2'b00, ~a, ~d};
    endtask
    // One flow event; the core picks source or destination address
    task flow(input logic [15:0] a);
        @(posedge ref_clk_i);
        {change_of_flow_o, change_of_flow_addr_o} <= {1'b1, a};
        @(posedge ref_clk_i);
        {change_of_flow_o, change_of_flow_addr_o} <= {1'b0, ~a};
    endtask
endmodule

//--- verification/trace_trigger_unit_tb.sv
// Self-checking bench of the trace trigger unit
`timescale 1ns/10ps
`include "trace_trigger_unit_map.vh"
module trace_trigger_unit_tb;
    logic        ref_clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        sys_reset_i = 1'b0;
    logic        secure_i = 1'b0;
    logic        dbg_busy = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [15:0] adr = 16'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] q;
    wire  [31:0] rdat;
    wire  [15:0] caddr, faddr;
    wire  [7:0]  cdata;
    wire         ack, valid, cwr, change_of_flow, tag_p, frc_p, active;
    int          failures = 0;
    int          n_checks = 0;
    int          n_frc = 0;
    int          n_tag = 0;
    logic [7:0]  rst_val [16] = '{8'hFF, 8'hFE, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0,
                                  8'h0, 8'h0, 8'h0, 8'h0, 8'hC0, 8'h40, 8'h01, 8'h0};

    cpu_bus_model cpu (.ref_clk_i(ref_clk_i), .cpu_valid_o(valid), .cpu_write_o(cwr), .cpu_addr_o(caddr),
        .cpu_data_o(cdata), .change_of_flow_o(change_of_flow), .change_of_flow_addr_o(faddr));
    trace_trigger_unit uut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .sys_reset_i(sys_reset_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .cpu_valid_i(valid), .cpu_write_i(cwr), .cpu_addr_i(caddr),
        .cpu_data_i(cdata), .change_of_flow_i(change_of_flow), .change_of_flow_addr_i(faddr), .secure_i(secure_i),
        .background_debug_state_i(dbg_busy), .tag_bkpt_o(tag_p), .force_bkpt_o(frc_p), .trace_active_o(active));

    // Clock and breakpoint pulse counters
    initial forever #25 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        n_frc += int'(frc_p === 1'b1);
        n_tag += int'(tag_p === 1'b1);
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // One classic cycle; ack is sampled at the edge, so no fixed latency is assumed
    task wb(input logic w, input logic [13:0] idx, input logic [7:0] d);
        int n;
        @(posedge ref_clk_i);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, idx, 2'b00, 24'h0, d};
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        {cyc, stb} <= 2'b00;
        if (n >= 50) begin
            failures++;
            tally_and_finish;
        end
    endtask
    task rdc(input logic [13:0] idx, input logic [7:0] e);
        wb(1'b0, idx, 8'h00);
        check(q, {24'h0, e});
    endtask
    // Arm with control c and mode m, run two bus cycles, count breakpoints
    task run(input logic [7:0] c, input logic [3:0] m, input logic [15:0] a1, a2, input logic [7:0] d,
             input int ef, et);
        int f0, t0;
        wb(1'b1, `IDX_TRIG, {4'h4, m});
        wb(1'b1, `IDX_CTRL, c);
        f0 = n_frc;
        t0 = n_tag;
        cpu.bus(a1, d);
        cpu.bus(a2, d);
        repeat (3) @(posedge ref_clk_i);
        check(32'(n_frc - f0), 32'(ef));
        check(32'(n_tag - t0), 32'(et));
    endtask
    task pulse_sys_reset;
        @(posedge ref_clk_i);
        sys_reset_i <= 1'b1;
        @(posedge ref_clk_i);
        sys_reset_i <= 1'b0;
    endtask

    task s_reset_values;
        for (int i = 0; i < 16; i++) rdc(14'h3010 + 14'(i), rst_val[i]);
    endtask
    task s_access;
        for (int i = 0; i < 16; i++) begin
            if (i < 8 || i == 11 || i > 13) begin
                wb(1'b1, 14'h3010 + 14'(i), 8'h5A);
                rdc(14'h3010 + 14'(i), i < 6 ? 8'h5A : rst_val[i]);
            end
        end
        wb(1'b1, 14'h0010, 8'hFF);
        rdc(14'h0010, 8'h00);
    endtask
    task s_modes;
        wb(1'b1, `IDX_CA_HI, 8'h10);
        wb(1'b1, `IDX_CA_LO, 8'h00);
        wb(1'b1, `IDX_CB_HI, 8'h20);
        wb(1'b1, `IDX_CB_LO, 8'h00);
        run(8'hD0, 4'h0, 16'h1000, 16'h0500, 8'h00, 1, 0);
        run(8'hD0, 4'h0, 16'h1001, 16'h0500, 8'h00, 0, 0);
        run(8'hF0, 4'h0, 16'h1000, 16'h0500, 8'h00, 0, 1);
        run(8'hD0, 4'h1, 16'h2000, 16'h0500, 8'h00, 1, 0);
        run(8'hD0, 4'h2, 16'h2000, 16'h1000, 8'h00, 0, 0);
        run(8'hD0, 4'h2, 16'h1000, 16'h2000, 8'h00, 1, 0);
        run(8'hD0, 4'h3, 16'h1000, 16'h0500, 8'h00, 1, 0);
        run(8'hD0, 4'h3, 16'h1000, 16'h0500, 8'h01, 0, 0);
        run(8'hD0, 4'h4, 16'h1000, 16'h0500, 8'h01, 1, 0);
        run(8'hD0, 4'h4, 16'h1000, 16'h0500, 8'h00, 0, 0);
        run(8'hD0, 4'h7, 16'h2000, 16'h0500, 8'h00, 1, 0);
        run(8'hD0, 4'h7, 16'h0FFF, 16'h2001, 8'h00, 0, 0);
        run(8'hD0, 4'h8, 16'h2001, 16'h1800, 8'h00, 1, 0);
        run(8'hD0, 4'h8, 16'h1000, 16'h2000, 8'h00, 0, 0);
    endtask
    task s_quiet;
        @(posedge ref_clk_i);
        secure_i <= 1'b1;
        run(8'hD0, 4'h0, 16'h1000, 16'h1000, 8'h00, 0, 0);
        {secure_i, dbg_busy} <= 2'b01;
        run(8'hD0, 4'h0, 16'h1000, 16'h1000, 8'h00, 0, 0);
        dbg_busy <= 1'b0;
    endtask
    task s_events;
        run(8'hC0, 4'h5, 16'h2000, 16'h0500, 8'h3C, 0, 0);
        rdc(`IDX_FIFO_X, 8'h81);
        rdc(`IDX_FIFO_LO, 8'h3C);
        rdc(`IDX_FIFO_X, 8'h00);
        run(8'hC0, 4'h6, 16'h2000, 16'h1000, 8'h11, 0, 0);
        cpu.bus(16'h2000, 8'h5D);
        rdc(`IDX_FIFO_X, 8'h81);
        rdc(`IDX_FIFO_LO, 8'h5D);
    endtask
    // Second entry equal to C is skipped in loop capture
    task s_flow;
        wb(1'b1, `IDX_TRIG, 8'h00);
        wb(1'b1, `IDX_CTRL, 8'hC8);
        cpu.flow(16'hABCD);
        cpu.flow(16'hABCD);
        cpu.flow(16'h1234);
        rdc(`IDX_CC_HI, 8'h12);
        rdc(`IDX_CC_LO, 8'h34);
        rdc(`IDX_COUNT, 8'h02);
        check({31'h0, active}, 32'h1);
        rdc(`IDX_FIFO_X, 8'h01);
        rdc(`IDX_FIFO_HI, 8'hAB);
        rdc(`IDX_FIFO_LO, 8'hCD);
        rdc(`IDX_FIFO_HI, 8'h12);
        rdc(`IDX_FIFO_LO, 8'h34);
        rdc(`IDX_FIFO_X, 8'h00);
    endtask
    task s_end_reset;
        wb(1'b1, `IDX_CA_HI, 8'h12);
        pulse_sys_reset;
        rdc(`IDX_CA_HI, 8'h12);
        rdc(`IDX_CTRL, 8'h88);
        check({31'h0, active}, 32'h0);
        wb(1'b1, `IDX_TRIG, 8'h40);
        pulse_sys_reset;
        rdc(`IDX_CA_HI, 8'hFF);
        rdc(`IDX_CTRL, 8'hC0);
        wb(1'b1, `IDX_CC_HI, 8'h30);
        wb(1'b1, `IDX_CC_LO, 8'h00);
        wb(1'b1, `IDX_CC_EXT, 8'h20);
        run(8'hC0, 4'h0, 16'h3000, 16'h0500, 8'h00, 1, 0);
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        s_reset_values;
        s_access;
        s_modes;
        s_quiet;
        s_events;
        s_flow;
        s_end_reset;
        tally_and_finish;
    end
endmodule

bind trace_trigger_unit trace_trigger_unit_checker chk (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cpu_valid_i(cpu_valid_i), .secure_i(secure_i), .background_debug_state_i(background_debug_state_i),
    .tag_bkpt_o(tag_bkpt_o), .force_bkpt_o(force_bkpt_o), .trace_active_o(trace_active_o));
